//--- pmwc_map.vh
/*
 Constants for the power mode and wakeup controller: mode codes,
 boot source codes, state codes, clock source codes, reset stretch.
 Assumes inclusion by pmwc_ctrl.v, the assertion module and the bench.
*/
`ifndef PMWC_MAP_VH
`define PMWC_MAP_VH

// ============================================================
// requested low-power mode (software configuration)
`define PMWC_MODE_SLEEP 2'h0
`define PMWC_MODE_DEEP 2'h1
`define PMWC_MODE_STANDBY 2'h2

// ============================================================
// boot source codes
`define PMWC_BOOT_FLASH 2'h0
`define PMWC_BOOT_SYSMEM 2'h1
`define PMWC_BOOT_SRAM 2'h2

// ============================================================
// system clock source select
`define PMWC_CLK_INTERNAL 2'h0
`define PMWC_CLK_EXTERNAL 2'h1
`define PMWC_CLK_PLL 2'h2

// ============================================================
// one-hot states
`define PMWC_ST_RUN 4'h1
`define PMWC_ST_SLEEP 4'h2
`define PMWC_ST_DEEP 4'h4
`define PMWC_ST_STANDBY 4'h8

// ============================================================
// widths and counts
`define PMWC_EXT_LINES 16
`define PMWC_RESET_STRETCH_NS 100
`define PMWC_CLK_PERIOD_NS 10
`define PMWC_RST_CNT_W 4

`endif

//--- pmwc_ctrl.v
/*
 Power mode and wakeup controller: run, sleep, deep-sleep and standby
 sequencing, wakeup source gathering, system reset generation, supply
 warning and boot source capture.
 Assumes all inputs synchronous to sys_clk; wakeup sources stay powered
 (always-on domain) and the core raises sleep_request for one cycle
 when it executes its wait-for-interrupt instruction.
*/
// What this block does
// - sleep gates core clock only
// - any interrupt or event ends sleep
// - deep-sleep stops core clocks, oscillators, PLL
// - deep-sleep keeps SRAM and register retention
// - deep-sleep ends on event lines, alarm, monitor
// - leaving deep-sleep selects internal fast oscillator
// - standby powers off domain, regulator, oscillators
// - standby loses state except backup registers
// - standby wakes on four sources only; supply below threshold also ends standby here, through the reset
// - boot pins pick flash, sysmem or SRAM
// - flash boot when nothing else chosen
// - system reset resets core and peripherals
// - hold reset while supply below threshold
// - monitor crossing raises warning interrupt
`timescale 1ns/100ps
`include "pmwc_map.vh"

module pmwc_ctrl (
	input wire sys_clk,
	input wire rst,
	input wire sleep_request,
	input wire [1:0] mode_config,
	input wire [1:0] clk_source_config,
	input wire irq_pending,
	input wire event_pending,
	input wire [15:0] external_event_lines,
	input wire rtc_alarm,
	input wire low_voltage_monitor,
	input wire supply_below_threshold,
	input wire external_reset_pin,
	input wire independent_watchdog,
	input wire wakeup_pin,
	input wire boot_select_pin,
	input wire boot_select_aux,
	output reg core_clk_en,
	output reg periph_clk_en,
	output reg internal_fast_osc_en,
	output reg external_fast_osc_en,
	output reg pll_en,
	output reg [1:0] sys_clk_source,
	output reg core_regulator_en,
	output reg domain_power_en,
	output reg retention_en,
	output reg state_lost,
	output reg sys_reset,
	output reg low_voltage_irq,
	output reg [1:0] boot_source,
	output reg [3:0] power_state
);

	localparam [3:0] ST_RUN = `PMWC_ST_RUN;
	localparam [3:0] ST_SLEEP = `PMWC_ST_SLEEP;
	localparam [3:0] ST_DEEP = `PMWC_ST_DEEP;
	localparam [3:0] ST_STANDBY = `PMWC_ST_STANDBY;
	localparam integer STRETCH_CYC =
		(`PMWC_RESET_STRETCH_NS + `PMWC_CLK_PERIOD_NS - 1) / `PMWC_CLK_PERIOD_NS;
	localparam [`PMWC_RST_CNT_W-1:0] STRETCH_LAST = STRETCH_CYC[`PMWC_RST_CNT_W-1:0];

	// ============================================================
	// helpers
	function [1:0] boot_decode;
		input sel;
		input aux;
		begin
			if (!sel) begin
				boot_decode = `PMWC_BOOT_FLASH;
			end else if (!aux) begin
				boot_decode = `PMWC_BOOT_SYSMEM;
			end else begin
				boot_decode = `PMWC_BOOT_SRAM;
			end
		end
	endfunction

	function at_stretch_end;
		input [`PMWC_RST_CNT_W-1:0] cnt;
		begin
			at_stretch_end = (cnt == STRETCH_LAST);
		end
	endfunction

	// ============================================================
	// edge detection and wakeup gathering
	reg wakeup_pin_prev;
	reg lvm_prev;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [`PMWC_RST_CNT_W-1:0] rst_cnt;
	reg boot_pending;
	reg standby_wake;
	reg [1:0] clk_cfg_seen;
	reg next_core_clk_en;
	reg next_periph_clk_en;
	reg next_internal_fast_osc_en;
	reg next_external_fast_osc_en;
	reg next_pll_en;
	reg [1:0] next_sys_clk_source;
	reg [1:0] next_clk_cfg_seen;
	reg next_core_regulator_en;
	reg next_domain_power_en;
	reg next_retention_en;
	wire wakeup_rise;
	wire lvm_cross;
	wire deep_wake;
	wire reset_cause;
	wire any_reset;
	wire stretch_done;

	assign wakeup_rise = wakeup_pin & ~wakeup_pin_prev;
	assign lvm_cross = low_voltage_monitor ^ lvm_prev;
	// all event-line sources reach the deep-sleep exit
	assign deep_wake = irq_pending | event_pending | (|external_event_lines) |
		rtc_alarm | low_voltage_monitor;
	// exactly the four standby exits
	always @* begin
		standby_wake = external_reset_pin | rtc_alarm | independent_watchdog |
			wakeup_rise;
	end
	// external pin and watchdog reset in any state; a standby exit is a reset too
	assign reset_cause = external_reset_pin | independent_watchdog | supply_below_threshold |
		(state == ST_STANDBY && standby_wake);

	// ============================================================
	// mode sequencing
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				// the core clock is off during the stretch, so a request then is noise
				if (sleep_request && !sys_reset) begin
					case (mode_config)
						`PMWC_MODE_DEEP: next_state = ST_DEEP;
						`PMWC_MODE_STANDBY: next_state = ST_STANDBY;
						default: next_state = ST_SLEEP;
					endcase
				end
			end
			ST_SLEEP: begin
				if (irq_pending | event_pending) begin
					next_state = ST_RUN;
				end
			end
			ST_DEEP: begin
				if (deep_wake) begin
					next_state = ST_RUN;
				end
			end
			ST_STANDBY: begin
				if (standby_wake) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	// ============================================================
	// edge history
	// cleared by rst only, so a pin still high after a standby exit
	// reset is not taken for a second rising edge
	always @(posedge sys_clk) begin
		if (rst) begin
			wakeup_pin_prev <= 1'b0;
			lvm_prev <= 1'b0;
		end else begin
			wakeup_pin_prev <= wakeup_pin;
			lvm_prev <= low_voltage_monitor;
		end
	end

	// ============================================================
	// state register and reset stretch
	assign any_reset = rst | reset_cause;
	assign stretch_done = at_stretch_end(rst_cnt);

	always @(posedge sys_clk) begin
		if (any_reset) begin
			state <= ST_RUN;
			power_state <= ST_RUN;
			rst_cnt <= {`PMWC_RST_CNT_W{1'b0}};
			sys_reset <= 1'b1;
		end else begin
			state <= next_state;
			power_state <= next_state;
			// reset stretched a fixed time after every cause goes away
			if (!stretch_done) begin
				rst_cnt <= rst_cnt + 1'b1;
			end else begin
				sys_reset <= 1'b0;
			end
		end
	end

	// ============================================================
	// boot source capture and state-loss flag
	always @(posedge sys_clk) begin
		if (rst) begin
			boot_pending <= 1'b1;
			state_lost <= 1'b1;
			boot_source <= `PMWC_BOOT_FLASH;
		end else if (reset_cause) begin
			boot_pending <= 1'b1;
			if (state == ST_STANDBY) begin
				state_lost <= 1'b1;
			end
		end else if (boot_pending && stretch_done) begin
			// boot pins sampled once, on the release edge
			boot_source <= boot_decode(boot_select_pin, boot_select_aux);
			boot_pending <= 1'b0;
			state_lost <= 1'b0;
		end
	end

	// ============================================================
	// supply warning, one cycle on either crossing direction
	always @(posedge sys_clk) begin
		if (any_reset) begin
			low_voltage_irq <= 1'b0;
		end else begin
			low_voltage_irq <= lvm_cross;
		end
	end

	// ============================================================
	// clock, oscillator and power enables
	always @* begin
		next_core_clk_en = core_clk_en;
		next_periph_clk_en = periph_clk_en;
		next_internal_fast_osc_en = internal_fast_osc_en;
		next_external_fast_osc_en = external_fast_osc_en;
		next_pll_en = pll_en;
		next_sys_clk_source = sys_clk_source;
		next_clk_cfg_seen = clk_cfg_seen;
		next_core_regulator_en = core_regulator_en;
		next_domain_power_en = domain_power_en;
		next_retention_en = retention_en;
		case (next_state)
			ST_SLEEP: begin
				next_core_clk_en = 1'b0;
				next_periph_clk_en = 1'b1;
			end
			ST_DEEP: begin
				next_core_clk_en = 1'b0;
				next_periph_clk_en = 1'b0;
				next_internal_fast_osc_en = 1'b0;
				next_external_fast_osc_en = 1'b0;
				next_pll_en = 1'b0;
				next_retention_en = 1'b1;
			end
			ST_STANDBY: begin
				next_core_clk_en = 1'b0;
				next_periph_clk_en = 1'b0;
				next_internal_fast_osc_en = 1'b0;
				next_external_fast_osc_en = 1'b0;
				next_pll_en = 1'b0;
				next_core_regulator_en = 1'b0;
				next_domain_power_en = 1'b0;
				next_retention_en = 1'b0;
			end
			default: begin
				// core and peripheral clocks return together at the end of the stretch
				next_retention_en = 1'b0;
				next_core_clk_en = ~sys_reset | stretch_done;
				next_periph_clk_en = ~sys_reset | stretch_done;
				if (state == ST_DEEP) begin
					// oscillators were off, so only internal is sure to run; the
					// old selection stays parked until software writes a new one
					next_internal_fast_osc_en = 1'b1;
					next_sys_clk_source = `PMWC_CLK_INTERNAL;
					next_clk_cfg_seen = clk_source_config;
				end else if (state == ST_RUN && !sys_reset &&
						clk_source_config != clk_cfg_seen) begin
					next_internal_fast_osc_en = 1'b1;
					next_external_fast_osc_en = (clk_source_config == `PMWC_CLK_EXTERNAL);
					next_pll_en = (clk_source_config == `PMWC_CLK_PLL);
					next_sys_clk_source = clk_source_config;
					next_clk_cfg_seen = clk_source_config;
				end
			end
		endcase
	end

	// ============================================================
	// enable registers, back to post-reset values on every reset cause
	always @(posedge sys_clk) begin
		if (any_reset) begin
			core_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			internal_fast_osc_en <= 1'b1;
			external_fast_osc_en <= 1'b0;
			pll_en <= 1'b0;
			sys_clk_source <= `PMWC_CLK_INTERNAL;
			clk_cfg_seen <= `PMWC_CLK_INTERNAL;
			core_regulator_en <= 1'b1;
			domain_power_en <= 1'b1;
			retention_en <= 1'b0;
		end else begin
			core_clk_en <= next_core_clk_en;
			periph_clk_en <= next_periph_clk_en;
			internal_fast_osc_en <= next_internal_fast_osc_en;
			external_fast_osc_en <= next_external_fast_osc_en;
			pll_en <= next_pll_en;
			sys_clk_source <= next_sys_clk_source;
			clk_cfg_seen <= next_clk_cfg_seen;
			core_regulator_en <= next_core_regulator_en;
			domain_power_en <= next_domain_power_en;
			retention_en <= next_retention_en;
		end
	end

endmodule

//--- pmwc_ctrl_props.sv
/* assertions on the ports of pmwc_ctrl; assumes rst high clears every state */
`timescale 1ns/100ps
`include "pmwc_map.vh"
module pmwc_ctrl_props (
	input wire sys_clk,
	input wire rst,
	input wire sleep_request,
	input wire [1:0] mode_config,
	input wire irq_pending,
	input wire event_pending,
	input wire [15:0] external_event_lines,
	input wire low_voltage_monitor,
	input wire supply_below_threshold,
	input wire core_clk_en,
	input wire periph_clk_en,
	input wire pll_en,
	input wire retention_en,
	input wire domain_power_en,
	input wire [1:0] sys_clk_source,
	input wire sys_reset,
	input wire low_voltage_irq,
	input wire [3:0] power_state
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ============================================================
	// mode entry and exit, reset hold and supply warning
	property p_slp;
		power_state == `PMWC_ST_RUN && sleep_request && !sys_reset &&
		mode_config == `PMWC_MODE_SLEEP
		|=> power_state == `PMWC_ST_SLEEP && !core_clk_en && periph_clk_en;
	endproperty
	a_slp: assert property (p_slp) else $error("sleep entry wrong");
	property p_swk;
		power_state == `PMWC_ST_SLEEP && (irq_pending || event_pending) |=> !power_state[1];
	endproperty
	a_swk: assert property (p_swk) else $error("sleep not left");
	property p_dp;
		power_state == `PMWC_ST_DEEP |-> !pll_en && !core_clk_en && retention_en;
	endproperty
	a_dp: assert property (p_dp) else $error("deep sleep clocks on");
	property p_dwk;
		power_state == `PMWC_ST_DEEP && |external_event_lines && !supply_below_threshold
		|=> power_state == `PMWC_ST_RUN && sys_clk_source == `PMWC_CLK_INTERNAL;
	endproperty
	a_dwk: assert property (p_dwk) else $error("deep sleep exit wrong");
	property p_sb;
		power_state == `PMWC_ST_STANDBY |-> !domain_power_en;
	endproperty
	a_sb: assert property (p_sb) else $error("standby domain powered");
	property p_bor;
		supply_below_threshold |=> sys_reset [*3];
	endproperty
	a_bor: assert property (p_bor) else $error("reset not held");
	property p_rst;
		sys_reset |-> !core_clk_en && !periph_clk_en;
	endproperty
	a_rst: assert property (p_rst) else $error("clocks run in reset");
	property p_lvd;
		$changed(low_voltage_monitor) |-> ##[1:3] low_voltage_irq;
	endproperty
	a_lvd: assert property (p_lvd) else $error("no supply warning");
	c_slp: cover property (power_state == `PMWC_ST_SLEEP);
	c_dp: cover property (power_state == `PMWC_ST_DEEP);
	c_sb: cover property (power_state == `PMWC_ST_STANDBY);
	c_lvi: cover property (low_voltage_irq);
endmodule
bind pmwc_ctrl pmwc_ctrl_props i_props (
	.sys_clk(sys_clk), .rst(rst), .sleep_request(sleep_request), .mode_config(mode_config),
	.irq_pending(irq_pending), .event_pending(event_pending),
	.external_event_lines(external_event_lines), .low_voltage_monitor(low_voltage_monitor),
	.supply_below_threshold(supply_below_threshold), .core_clk_en(core_clk_en),
	.periph_clk_en(periph_clk_en), .pll_en(pll_en), .retention_en(retention_en),
	.domain_power_en(domain_power_en), .sys_clk_source(sys_clk_source),
	.sys_reset(sys_reset), .low_voltage_irq(low_voltage_irq), .power_state(power_state)
);

//--- pmwc_core_model.sv
/* core side model: sleep instruction, mode setting, boot straps; assumes sys_clk */
`timescale 1ns/100ps
module pmwc_core_model (
	input wire sys_clk,
	output logic sleep_request = 1'h0,
	output logic [1:0] mode_config = 2'h0,
	output logic boot_select_pin = 1'h0,
	output logic boot_select_aux = 1'h0
);
	// straps are held steady so the level sampled at reset release is defined
	task strap(input logic p, a);
		@(posedge sys_clk);
		boot_select_pin <= p;
		boot_select_aux <= a;
	endtask
	task wfi(input logic [1:0] m);
		@(posedge sys_clk);
		mode_config <= m;
		@(posedge sys_clk);
		sleep_request <= 1'h1;
		@(posedge sys_clk);
		sleep_request <= 1'h0;
	endtask
endmodule

//--- pmwc_ctrl_tb_top.sv
/* self-checking bench for pmwc_ctrl; assumes the core model and the checker */
`timescale 1ns/100ps
`include "pmwc_map.vh"
module pmwc_ctrl_tb_top;
	logic sys_clk = 1'h0, rst = 1'h1, irq_pending = 1'h0, event_pending = 1'h0;
	logic rtc_alarm = 1'h0, low_voltage_monitor = 1'h0, supply_below_threshold = 1'h0;
	logic external_reset_pin = 1'h0, independent_watchdog = 1'h0, wakeup_pin = 1'h0;
	logic [1:0] clk_source_config = 2'h0;
	logic [15:0] external_event_lines = 16'h0;
	wire sleep_request, boot_select_pin, boot_select_aux, core_clk_en, periph_clk_en;
	wire internal_fast_osc_en, external_fast_osc_en, pll_en, core_regulator_en, domain_power_en;
	wire retention_en, state_lost, sys_reset, low_voltage_irq;
	wire [1:0] mode_config, sys_clk_source, boot_source;
	wire [3:0] power_state;
	int err_count = 0, n_tests = 0;
	pmwc_ctrl i_dut (
		.sys_clk(sys_clk), .rst(rst), .sleep_request(sleep_request), .mode_config(mode_config),
		.clk_source_config(clk_source_config), .irq_pending(irq_pending),
		.event_pending(event_pending), .external_event_lines(external_event_lines),
		.rtc_alarm(rtc_alarm), .low_voltage_monitor(low_voltage_monitor),
		.supply_below_threshold(supply_below_threshold),
		.external_reset_pin(external_reset_pin), .independent_watchdog(independent_watchdog),
		.wakeup_pin(wakeup_pin), .boot_select_pin(boot_select_pin),
		.boot_select_aux(boot_select_aux), .core_clk_en(core_clk_en),
		.periph_clk_en(periph_clk_en), .internal_fast_osc_en(internal_fast_osc_en),
		.external_fast_osc_en(external_fast_osc_en), .pll_en(pll_en),
		.sys_clk_source(sys_clk_source), .core_regulator_en(core_regulator_en),
		.domain_power_en(domain_power_en), .retention_en(retention_en),
		.state_lost(state_lost), .sys_reset(sys_reset), .low_voltage_irq(low_voltage_irq),
		.boot_source(boot_source), .power_state(power_state)
	);
	pmwc_core_model i_core (
		.sys_clk(sys_clk), .sleep_request(sleep_request), .mode_config(mode_config),
		.boot_select_pin(boot_select_pin), .boot_select_aux(boot_select_aux)
	);
	initial forever #5 sys_clk = ~sys_clk;
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// bounded wait for the reset stretch to end
	task wait_boot;
		for (int k = 0; k < 40 && sys_reset !== 1'h0; k++) step(1);
		chk("released", sys_reset, 8'h00);
	endtask
	task t_boot(input logic p, a, input logic [1:0] exp);
		i_core.strap(p, a);
		rst <= 1'h1;
		step(10);
		@(posedge sys_clk) rst <= 1'h0;
		wait_boot;
		chk("boot", boot_source, exp);
	endtask
	task t_low_power;
		i_core.wfi(`PMWC_MODE_SLEEP);
		step(1);
		chk("clks", {power_state, core_clk_en, periph_clk_en}, 8'h09);
		@(posedge sys_clk) irq_pending <= 1'h1;
		@(posedge sys_clk) irq_pending <= 1'h0;
		step(1);
		chk("swake", power_state, `PMWC_ST_RUN);
		@(posedge sys_clk) clk_source_config <= `PMWC_CLK_PLL;
		i_core.wfi(`PMWC_MODE_DEEP);
		step(1);
		chk("deep", {internal_fast_osc_en, external_fast_osc_en, pll_en, retention_en}, 8'h01);
		@(posedge sys_clk) external_event_lines <= 16'h8000;
		@(posedge sys_clk) external_event_lines <= 16'h0;
		#1;
		chk("dwake", {power_state, 2'h0, sys_clk_source}, 8'h10);
		step(2);
		chk("parked", {external_fast_osc_en, pll_en, sys_clk_source}, 8'h00);
		@(posedge sys_clk) clk_source_config <= `PMWC_CLK_EXTERNAL;
		step(1);
		chk("extclk", {external_fast_osc_en, pll_en, sys_clk_source}, 8'h09);
		i_core.wfi(`PMWC_MODE_STANDBY);
		@(posedge sys_clk) irq_pending <= 1'h1;
		event_pending <= 1'h1;
		step(2);
		chk("stby", {core_regulator_en, domain_power_en, power_state}, 8'h08);
		@(posedge sys_clk) irq_pending <= 1'h0;
		event_pending <= 1'h0;
		@(posedge sys_clk) wakeup_pin <= 1'h1;
		step(1);
		chk("swake", {sys_reset, state_lost}, 8'h03);
		@(posedge sys_clk) wakeup_pin <= 1'h0;
		wait_boot;
	endtask
	task t_supply;
		logic seen;
		@(posedge sys_clk) supply_below_threshold <= 1'h1;
		step(30);
		chk("held", sys_reset, 8'h01);
		@(posedge sys_clk) supply_below_threshold <= 1'h0;
		wait_boot;
		chk("freed", sys_reset, 8'h00);
		@(posedge sys_clk) independent_watchdog <= 1'h1;
		@(posedge sys_clk) independent_watchdog <= 1'h0;
		#1;
		chk("wdog", {sys_reset, state_lost}, 8'h02);
		wait_boot;
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk) low_voltage_monitor <= !low_voltage_monitor;
			seen = 1'h0;
			repeat (4) begin
				step(1);
				seen |= low_voltage_irq;
			end
			chk("warn", seen, 8'h01);
		end
	endtask
	initial begin
		t_boot(1'h0, 1'h0, `PMWC_BOOT_FLASH);
		t_boot(1'h1, 1'h0, `PMWC_BOOT_SYSMEM);
		t_boot(1'h1, 1'h1, `PMWC_BOOT_SRAM);
		t_low_power;
		t_supply;
		tally_and_finish;
	end
	initial begin
		#20000;
		err_count++;
		tally_and_finish;
	end
endmodule
